/* File: rx_buffer_defines.svh */
`ifndef RX_BUFFER_DEFINES_SVH
`define RX_BUFFER_DEFINES_SVH

// register byte offsets
`define RB_A_CTRL        8'h00
`define RB_A_STATUS      8'h04
`define RB_A_FLOOR       8'h08
`define RB_A_BUF_PTR     8'h0c
`define RB_A_BUF_WORDS   8'h10
`define RB_A_DESC_PTR    8'h14
`define RB_A_UPPER       8'h18
`define RB_A_RES_RD      8'h1c
`define RB_A_RES_WR      8'h20
`define RB_A_RING_START  8'h24
`define RB_A_RING_END    8'h28
`define RB_A_STATE       8'h2c

// control bits
`define RB_CTRL_EN       0
`define RB_CTRL_BUS32    1
`define RB_CTRL_ACC_ERR  2
`define RB_CTRL_ACC_RUNT 3
`define RB_CTRL_RD_RING  4

// status bits
`define RB_ST_DESC_EXH   0
`define RB_ST_BUF_EXH    1
`define RB_ST_AREA_EXC   2

// reset values
`define RB_FLOOR_RESET   16'h02f8
`define RB_CTRL_RESET    5'h00

// descriptor field indices
`define RB_DESC_STATUS   3'h0
`define RB_DESC_COUNT    3'h1
`define RB_DESC_PTR0     3'h2
`define RB_DESC_PTR1     3'h3
`define RB_DESC_SEQ      3'h4
`define RB_DESC_LINK     3'h5
`define RB_DESC_OWNER    3'h6
`define RB_RES_LAST      2'h3

// smallest legal frame in bytes
`define RB_RUNT_BYTES    16'h0040

`endif

/* File: rx_buffer_pkg.sv */
package rx_buffer_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_LINK_RECHECK,
      ST_OWNER_RELEASE,
      ST_DATA,
      ST_DRAIN,
      ST_DESC_WRITE,
      ST_LINK_READ,
      ST_OWNER_CLEAR,
      ST_RES_WAIT,
      ST_RES_READ
   } state_t;

   typedef struct packed {
      logic        we;
      logic        lock;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_t;

endpackage

/* File: rx_buffer_resource_manager.sv */
`include "rx_buffer_defines.svh"

// Overview of operation
// - a packet starts in a fresh buffer once remaining words drop below the floor
// - floor count resets to 760 words
// - in 32-bit mode the floor's lsb is forced low for comparison
// - a packet always lies contiguously inside one buffer area
// - stored list end at reception start: re-read link, stop if still set
// - data written from current buffer address; words decrement per word written
// - accepted packet: write five status words, then read the link field
// - list end seen: keep link address, flag descriptors exhausted, owner untouched
// - link open: advance descriptor pointer and clear finished owner field
// - the seven-word descriptor is one locked block access
// - after acceptance, below floor remaining words trigger a resource fetch
// - rejected runt or error packets restore buffer pointers
// - saved pointer and word copies are reloaded on rejection
// - on overflow, DMA halts and nothing is written outside given resources
// - after exhaustion, next reception re-reads link and follows appended list
// - owner kept while exhausted, released by writing zero once appended
// - buffer exhausted flag set when read pointer meets write pointer
// - software refills ring and clears flag; device re-reads ring after clear
// - overrun truncates, flags area exceeded, fetches new buffer, no descriptor
// - link lsb is the list end flag, other bits the next address
// - resource descriptor: four words in one block, pointer then count
module rx_buffer_resource_manager (
   input  wire logic                      i_mclk,
   input  wire logic                      i_resetn,
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [7:0]                i_paddr,
   input  wire logic [31:0]               i_pwdata,
   output logic      [31:0]               o_prdata,
   output logic                           o_pready,
   output logic                           o_pslverr,
   input  wire logic                      i_rx_valid,
   input  wire logic [31:0]               i_rx_data,
   input  wire logic                      i_rx_last,
   input  wire logic                      i_rx_error,
   output logic                           o_rx_ready,
   output logic                           o_mem_req,
   output rx_buffer_pkg::mem_req_t        o_mem,
   input  wire logic                      i_mem_ack,
   input  wire logic [31:0]               i_mem_rdata
);

   rx_buffer_pkg::state_t state;
   logic [4:0]  ctrl;
   logic [2:0]  flags;
   logic [15:0] floor;
   logic [31:0] cur_ptr;
   logic [31:0] remaining;
   logic [31:0] saved_ptr;
   logic [31:0] saved_words;
   logic [15:0] cur_desc;
   logic [15:0] desc_upper;
   logic [15:0] ring_upper;
   logic [15:0] resource_read_pointer;
   logic [15:0] resource_write_pointer;
   logic [15:0] ring_start;
   logic [15:0] ring_end;
   logic [15:0] link_hold;
   logic        eol_stored;
   logic [2:0]  idx;
   logic [15:0] bytes;
   logic        last_held;
   logic        err_held;
   logic        trunc;
   logic        cmd;
   logic [7:0]  rba_seq;
   logic [7:0]  pkt_seq;

   wire        bus32      = ctrl[`RB_CTRL_BUS32];
   wire [15:0] floor_eff  = bus32 ? {floor[15:1], 1'b0} : floor;
   wire [15:0] step       = bus32 ? 16'h0004 : 16'h0002;
   wire [31:0] step32     = {16'h0000, step};
   wire [31:0] wpb        = bus32 ? 32'h0000_0002 : 32'h0000_0001;
   wire [15:0] idx_off    = bus32 ? {11'h000, idx, 2'b00} : {12'h000, idx, 1'b0};
   wire [15:0] bytes_next = bytes + (bus32 ? 16'h0004 : 16'h0002);
   wire        mem_done   = o_mem_req & i_mem_ack;
   wire        beat_take  = i_rx_valid & o_rx_ready;
   wire        no_room    = remaining < wpb;
   wire        below      = remaining < {16'h0000, floor_eff};
   wire        runt_next  = bytes_next < `RB_RUNT_BYTES;
   wire        runt_now   = bytes < `RB_RUNT_BYTES;
   wire        reject     = (err_held & ~ctrl[`RB_CTRL_ACC_ERR])
                          | (runt_next & ~ctrl[`RB_CTRL_ACC_RUNT]);
   wire        link_eol   = i_mem_rdata[0];
   wire [15:0] next_rrp_raw = resource_read_pointer + {step[13:0], 2'b00};
   wire [15:0] next_rrp   = (next_rrp_raw == ring_end) ? ring_start : next_rrp_raw;

   // apb decode
   wire        apb_setup  = i_psel & ~i_penable;
   wire        apb_wr     = i_psel & i_penable & o_pready & i_pwrite;
   wire        hit        = (i_paddr <= `RB_A_STATE) && (i_paddr[1:0] == 2'b00);
   wire [2:0]  w1c        = (apb_wr && i_paddr == `RB_A_STATUS) ? i_pwdata[2:0] : 3'h0;
   wire [31:0] rd_mux =
        (i_paddr == `RB_A_CTRL)       ? {27'h0, ctrl} :
        (i_paddr == `RB_A_STATUS)     ? {29'h0, flags} :
        (i_paddr == `RB_A_FLOOR)      ? {16'h0, floor_eff} :
        (i_paddr == `RB_A_BUF_PTR)    ? cur_ptr :
        (i_paddr == `RB_A_BUF_WORDS)  ? remaining :
        (i_paddr == `RB_A_DESC_PTR)   ? {15'h0, eol_stored, cur_desc} :
        (i_paddr == `RB_A_UPPER)      ? {ring_upper, desc_upper} :
        (i_paddr == `RB_A_RES_RD)     ? {16'h0, resource_read_pointer} :
        (i_paddr == `RB_A_RES_WR)     ? {16'h0, resource_write_pointer} :
        (i_paddr == `RB_A_RING_START) ? {16'h0, ring_start} :
        (i_paddr == `RB_A_RING_END)   ? {16'h0, ring_end} :
        (i_paddr == `RB_A_STATE)      ? {12'h0, 4'(state), rba_seq, pkt_seq} :
        32'h0000_0000;

   // hardware-set events; a set in the same cycle as a clear wins
   wire set_desc = (state == rx_buffer_pkg::ST_LINK_READ) & mem_done & link_eol;
   wire set_buf  = (state == rx_buffer_pkg::ST_RES_READ) & mem_done
                 & (idx[1:0] == `RB_RES_LAST) & (next_rrp == resource_write_pointer);
   wire set_area = (state == rx_buffer_pkg::ST_DATA) & beat_take & no_room;
   wire [2:0] set_vec = {set_area, set_buf, set_desc};

   // memory walk request selection
   wire walk_desc = (state == rx_buffer_pkg::ST_DESC_WRITE)
                  | (state == rx_buffer_pkg::ST_LINK_READ)
                  | (state == rx_buffer_pkg::ST_OWNER_CLEAR);
   wire walk_res  = state == rx_buffer_pkg::ST_RES_READ;
   wire walk_one  = (state == rx_buffer_pkg::ST_LINK_RECHECK)
                  | (state == rx_buffer_pkg::ST_OWNER_RELEASE);
   wire walk      = walk_desc | walk_res | walk_one;
   wire iss_we    = (state == rx_buffer_pkg::ST_DESC_WRITE)
                  | (state == rx_buffer_pkg::ST_OWNER_CLEAR)
                  | (state == rx_buffer_pkg::ST_OWNER_RELEASE);
   wire [15:0] one_lo = (state == rx_buffer_pkg::ST_OWNER_RELEASE) ? link_hold + step : link_hold;
   wire [31:0] iss_addr =
        walk_desc ? {desc_upper, cur_desc + idx_off} :
        walk_res  ? {ring_upper, resource_read_pointer + idx_off} :
        {desc_upper, one_lo};
   wire [15:0] desc_word =
        (idx == `RB_DESC_STATUS) ? {13'h0, runt_now, err_held, ~err_held} :
        (idx == `RB_DESC_COUNT)  ? bytes :
        (idx == `RB_DESC_PTR0)   ? saved_ptr[15:0] :
        (idx == `RB_DESC_PTR1)   ? saved_ptr[31:16] :
        (idx == `RB_DESC_SEQ)    ? {rba_seq, pkt_seq} :
        16'h0000;
   wire [31:0] iss_wdata = {16'h0000, desc_word};

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_prdata    <= 32'h0000_0000;
         o_pready    <= 1'b0;
         o_pslverr   <= 1'b0;
         o_rx_ready  <= 1'b0;
         o_mem_req   <= 1'b0;
         o_mem       <= '0;
         state       <= rx_buffer_pkg::ST_IDLE;
         ctrl        <= `RB_CTRL_RESET;
         flags       <= 3'h0;
         floor       <= `RB_FLOOR_RESET;
         cur_ptr     <= 32'h0000_0000;
         remaining   <= 32'h0000_0000;
         saved_ptr   <= 32'h0000_0000;
         saved_words <= 32'h0000_0000;
         cur_desc    <= 16'h0000;
         desc_upper  <= 16'h0000;
         ring_upper  <= 16'h0000;
         resource_read_pointer         <= 16'h0000;
         resource_write_pointer         <= 16'h0000;
         ring_start  <= 16'h0000;
         ring_end    <= 16'h0000;
         link_hold   <= 16'h0000;
         eol_stored  <= 1'b0;
         idx         <= 3'h0;
         bytes       <= 16'h0000;
         last_held   <= 1'b0;
         err_held    <= 1'b0;
         trunc       <= 1'b0;
         cmd         <= 1'b0;
         rba_seq     <= 8'h00;
         pkt_seq     <= 8'h00;
      end
      else
      begin
         o_pready  <= apb_setup;
         o_pslverr <= apb_setup & ~hit;
         if (apb_setup)
            o_prdata <= rd_mux;
         flags <= (flags & ~w1c) | set_vec;
         if (apb_wr)
         begin
            case (i_paddr)
               `RB_A_CTRL:       ctrl <= i_pwdata[4:0];
               `RB_A_FLOOR:      floor <= i_pwdata[15:0];
               `RB_A_BUF_PTR:    cur_ptr <= i_pwdata;
               `RB_A_BUF_WORDS:  remaining <= i_pwdata;
               `RB_A_UPPER:      {ring_upper, desc_upper} <= i_pwdata;
               `RB_A_RES_RD:     resource_read_pointer <= i_pwdata[15:0];
               `RB_A_RES_WR:     resource_write_pointer <= i_pwdata[15:0];
               `RB_A_RING_START: ring_start <= i_pwdata[15:0];
               `RB_A_RING_END:   ring_end <= i_pwdata[15:0];
               `RB_A_DESC_PTR:
               begin
                  cur_desc   <= {i_pwdata[15:1], 1'b0};
                  eol_stored <= 1'b0;
               end
               default: ;
            endcase
         end
         if (mem_done)
            o_mem_req <= 1'b0;
         // one idle cycle between walk accesses keeps issue logic simple
         if (walk && !o_mem_req)
         begin
            o_mem_req <= 1'b1;
            o_mem     <= '{iss_we, walk_desc | walk_res, iss_addr, iss_wdata};
         end
         case (state)
            rx_buffer_pkg::ST_IDLE:
            begin
               if (ctrl[`RB_CTRL_RD_RING])
               begin
                  cmd   <= 1'b1;
                  state <= rx_buffer_pkg::ST_RES_WAIT;
               end
               else if (ctrl[`RB_CTRL_EN] && i_rx_valid && eol_stored)
                  state <= rx_buffer_pkg::ST_LINK_RECHECK;
               else if (ctrl[`RB_CTRL_EN] && i_rx_valid)
               begin
                  saved_ptr   <= cur_ptr;
                  saved_words <= remaining;
                  bytes       <= 16'h0000;
                  err_held    <= 1'b0;
                  trunc       <= 1'b0;
                  o_rx_ready  <= 1'b1;
                  state       <= rx_buffer_pkg::ST_DATA;
               end
            end
            rx_buffer_pkg::ST_LINK_RECHECK:
            begin
               if (mem_done && link_eol)
               begin
                  o_rx_ready <= 1'b1;
                  trunc      <= 1'b0; // stale overrun must not start a fetch
                  state      <= rx_buffer_pkg::ST_DRAIN;
               end
               else if (mem_done)
               begin
                  cur_desc   <= {i_mem_rdata[15:1], 1'b0};
                  eol_stored <= 1'b0;
                  idx        <= `RB_DESC_OWNER;
                  state      <= rx_buffer_pkg::ST_OWNER_RELEASE;
               end
            end
            rx_buffer_pkg::ST_OWNER_RELEASE:
            begin
               if (mem_done)
               begin
                  saved_ptr   <= cur_ptr;
                  saved_words <= remaining;
                  bytes       <= 16'h0000;
                  err_held    <= 1'b0;
                  trunc       <= 1'b0;
                  o_rx_ready  <= 1'b1;
                  state       <= rx_buffer_pkg::ST_DATA;
               end
            end
            rx_buffer_pkg::ST_DATA:
            begin
               if (beat_take)
               begin
                  o_rx_ready <= 1'b0;
                  last_held  <= i_rx_last;
                  err_held   <= err_held | i_rx_error;
                  if (no_room)
                  begin
                     trunc      <= 1'b1;
                     o_rx_ready <= ~i_rx_last;
                     state      <= i_rx_last ? rx_buffer_pkg::ST_RES_WAIT
                                             : rx_buffer_pkg::ST_DRAIN;
                  end
                  else
                  begin
                     o_mem_req <= 1'b1;
                     o_mem     <= '{1'b1, 1'b0, cur_ptr, i_rx_data};
                  end
               end
               if (mem_done)
               begin
                  cur_ptr   <= cur_ptr + step32;
                  remaining <= remaining - wpb;
                  bytes     <= bytes_next;
                  if (!last_held)
                     o_rx_ready <= 1'b1;
                  else if (reject)
                  begin
                     cur_ptr   <= saved_ptr;
                     remaining <= saved_words;
                     state     <= rx_buffer_pkg::ST_IDLE;
                  end
                  else
                  begin
                     idx   <= `RB_DESC_STATUS;
                     state <= rx_buffer_pkg::ST_DESC_WRITE;
                  end
               end
            end
            rx_buffer_pkg::ST_DRAIN:
            begin
               // frame is consumed and dropped; memory stays untouched
               if (beat_take && i_rx_last)
               begin
                  o_rx_ready <= 1'b0;
                  state      <= trunc ? rx_buffer_pkg::ST_RES_WAIT : rx_buffer_pkg::ST_IDLE;
               end
            end
            rx_buffer_pkg::ST_DESC_WRITE:
            begin
               if (mem_done)
               begin
                  idx <= idx + 3'h1;
                  if (idx == `RB_DESC_SEQ)
                     state <= rx_buffer_pkg::ST_LINK_READ;
               end
            end
            rx_buffer_pkg::ST_LINK_READ:
            begin
               if (mem_done && link_eol)
               begin
                  link_hold  <= iss_addr[15:0];
                  eol_stored <= 1'b1;
                  idx        <= 3'h0;
                  pkt_seq    <= pkt_seq + 8'h01;
                  state      <= below ? rx_buffer_pkg::ST_RES_WAIT
                                      : rx_buffer_pkg::ST_IDLE;
               end
               else if (mem_done)
               begin
                  link_hold <= {i_mem_rdata[15:1], 1'b0};
                  idx       <= `RB_DESC_OWNER;
                  state     <= rx_buffer_pkg::ST_OWNER_CLEAR;
               end
            end
            rx_buffer_pkg::ST_OWNER_CLEAR:
            begin
               if (mem_done)
               begin
                  cur_desc <= link_hold;
                  idx      <= 3'h0;
                  pkt_seq  <= pkt_seq + 8'h01;
                  state    <= below ? rx_buffer_pkg::ST_RES_WAIT
                                    : rx_buffer_pkg::ST_IDLE;
               end
            end
            rx_buffer_pkg::ST_RES_WAIT:
            begin
               if (!flags[`RB_ST_BUF_EXH])
               begin
                  idx   <= 3'h0;
                  state <= rx_buffer_pkg::ST_RES_READ;
               end
            end
            rx_buffer_pkg::ST_RES_READ:
            begin
               if (mem_done)
               begin
                  idx <= idx + 3'h1;
                  case (idx[1:0])
                     2'h0:    cur_ptr[15:0]    <= i_mem_rdata[15:0];
                     2'h1:    cur_ptr[31:16]   <= i_mem_rdata[15:0];
                     2'h2:    remaining[15:0]  <= i_mem_rdata[15:0];
                     default: remaining[31:16] <= i_mem_rdata[15:0];
                  endcase
                  if (idx[1:0] == `RB_RES_LAST)
                  begin
                     resource_read_pointer  <= next_rrp;
                     idx  <= 3'h0;
                     cmd  <= 1'b0;
                     ctrl[`RB_CTRL_RD_RING] <= 1'b0;
                     if (!cmd)
                     begin
                        rba_seq <= rba_seq + 8'h01;
                        pkt_seq <= 8'h00;
                     end
                     state <= rx_buffer_pkg::ST_IDLE;
                  end
               end
            end
            default: state <= rx_buffer_pkg::ST_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   sequence seq_link_end;
      state == rx_buffer_pkg::ST_LINK_READ && mem_done && link_eol;
   endsequence
   sequence seq_link_open;
      state == rx_buffer_pkg::ST_LINK_READ && mem_done && !link_eol;
   endsequence
   sequence seq_overrun;
      state == rx_buffer_pkg::ST_DATA && beat_take && no_room;
   endsequence

   chk_floor_reset: assert property ($rose(i_resetn) |-> floor == 16'h02f8)
      else $error("floor count not at reset value");
   chk_floor_even: assert property (bus32 |-> rd_mux[0] == 1'b0 || i_paddr != `RB_A_FLOOR)
      else $error("floor lsb not forced in 32-bit mode");
   chk_word_decrement: assert property (
      state == rx_buffer_pkg::ST_DATA && mem_done
      |=> remaining == $past(remaining) - $past(wpb) || state == rx_buffer_pkg::ST_IDLE)
      else $error("remaining words not decremented");
   chk_exhaust_keep: assert property (seq_link_end |=>
      flags[`RB_ST_DESC_EXH] && eol_stored && state != rx_buffer_pkg::ST_OWNER_CLEAR)
      else $error("exhaustion handling wrong");
   chk_owner_clear: assert property (seq_link_open |=> ##1
      o_mem_req && o_mem.we && o_mem.lock && o_mem.wdata == 32'h0)
      else $error("owner clear not issued in block");
   chk_reject_restore: assert property (
      state == rx_buffer_pkg::ST_DATA && mem_done && last_held && reject
      |=> cur_ptr == $past(saved_ptr) && remaining == $past(saved_words))
      else $error("pointers not restored on reject");
   chk_overrun_flag: assert property (seq_overrun |=>
      flags[`RB_ST_AREA_EXC] && !o_mem_req && state != rx_buffer_pkg::ST_DESC_WRITE)
      else $error("overrun not flagged");
   chk_drain_quiet: assert property (
      state == rx_buffer_pkg::ST_DRAIN |-> !o_mem_req)
      else $error("memory access while draining");
   chk_ring_hold: assert property (
      state == rx_buffer_pkg::ST_RES_WAIT && flags[`RB_ST_BUF_EXH] [*2] |-> !o_mem_req)
      else $error("ring read while exhausted");
   chk_floor_fetch: assert property (
      state == rx_buffer_pkg::ST_OWNER_CLEAR && mem_done && below
      |=> state == rx_buffer_pkg::ST_RES_WAIT)
      else $error("resource fetch missed below floor");

endmodule

/* File: rx_mem_model.sv */
module rx_mem_model (
   input  wire logic                    i_mclk,
   input  wire logic                    i_mem_req,
   input  wire rx_buffer_pkg::mem_req_t i_mem,
   input  wire logic [1:0]              i_wait,
   output logic                         o_mem_ack,
   output logic [31:0]                  o_mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [0:1023];
   logic [1:0]  cnt = 2'h0;
   initial o_mem_ack = 1'b0;
   initial o_mem_rdata = 32'h0;
   always @(posedge i_mclk)
   begin
      o_mem_ack <= 1'b0;
      // stale read data flips so it never passes for valid
      o_mem_rdata <= ~o_mem_rdata;
      if (i_mem_req && !o_mem_ack)
      begin
         cnt <= cnt + 2'h1;
         if (cnt >= i_wait)
         begin
            o_mem_ack <= 1'b1;
            cnt <= 2'h0;
            if (i_mem.we)
               mem[i_mem.addr[11:2]] <= i_mem.wdata;
            else
               o_mem_rdata <= mem[i_mem.addr[11:2]];
         end
      end
   end
endmodule

/* File: test_rx_buffer_resource_manager.sv */
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module test_rx_buffer_resource_manager;
   timeunit 1ns;
   timeprecision 1ns;
   logic                    mclk, resetn, psel, penable, pwrite, pready, pslverr, err_seen;
   logic [7:0]              paddr;
   logic [31:0]             pwdata, prdata, r, rx_data, mem_rdata;
   logic                    rx_valid, rx_last, rx_error, rx_ready, mem_req, mem_ack;
   logic [1:0]              wait_cyc;
   rx_buffer_pkg::mem_req_t mem;
   int                      num_errors = 0;
   int                      checks_done = 0;
   rx_buffer_resource_manager uut (.i_mclk(mclk), .i_resetn(resetn), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rx_valid(rx_valid),
      .i_rx_data(rx_data), .i_rx_last(rx_last), .i_rx_error(rx_error),
      .o_rx_ready(rx_ready), .o_mem_req(mem_req), .o_mem(mem), .i_mem_ack(mem_ack),
      .i_mem_rdata(mem_rdata));
   rx_mem_model mm (.i_mclk(mclk), .i_mem_req(mem_req), .i_mem(mem), .i_wait(wait_cyc),
      .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(n, e, r)
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 60; k++)
      begin
         apb(1'b0, 8'h2c, 32'h0);
         if (r[19:16] === 4'h0)
            break;
      end
   endtask
   task automatic frame(input int beats, input logic err);
      for (int i = 0; i < beats; i++)
      begin
         rx_valid <= 1'b1;
         rx_data <= 32'hc0de0000 | i;
         rx_last <= (i == beats - 1);
         rx_error <= err;
         do @(posedge mclk); while (rx_ready !== 1'b1);
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_error <= 1'b0;
      wait_idle();
   endtask
   task automatic finish_test();
      if (num_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial
   begin
      #3000000;
      num_errors++;
      finish_test();
   end
   initial
   begin
      {resetn, psel, penable, pwrite, paddr, pwdata, rx_valid, rx_data} = '0;
      {rx_last, rx_error, wait_cyc} = '0;
      mm.mem[64] = 32'h400;
      mm.mem[65] = 32'h0;
      mm.mem[66] = 32'h40;
      mm.mem[67] = 32'h0;
      mm.mem[133] = 32'h240;
      mm.mem[134] = 32'h1;
      mm.mem[144] = 32'hdead;
      mm.mem[149] = 32'h1;
      mm.mem[150] = 32'h1;
      mm.mem[68] = 32'h600;
      mm.mem[69] = 32'h0;
      mm.mem[70] = 32'h20;
      mm.mem[71] = 32'h0;
      mm.mem[72] = 32'h800;
      mm.mem[73] = 32'h0;
      mm.mem[74] = 32'h40;
      mm.mem[75] = 32'h0;
      mm.mem[165] = 32'h1;
      mm.mem[176] = 32'hdead;
      mm.mem[181] = 32'h300;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      rd_chk("floor_reset", 8'h08, 32'h2f8);
      apb(1'b1, 8'h30, 32'h1);
      `CHK("unmapped_err", 1'b1, err_seen)
      apb(1'b1, 8'h00, 32'h3);
      apb(1'b1, 8'h08, 32'h2f9);
      rd_chk("floor_bus32", 8'h08, 32'h2f8);
      apb(1'b1, 8'h08, 32'h10);
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h1c, 32'h100);
      apb(1'b1, 8'h20, 32'h120);
      apb(1'b1, 8'h24, 32'h100);
      apb(1'b1, 8'h28, 32'h130);
      apb(1'b1, 8'h14, 32'h200);
      apb(1'b1, 8'h00, 32'h1b);
      wait_idle();
      rd_chk("ring_ptr", 8'h0c, 32'h400);
      rd_chk("ring_words", 8'h10, 32'h40);
      frame(2, 1'b0);
      rd_chk("ptr_after", 8'h0c, 32'h408);
      rd_chk("words_after", 8'h10, 32'h3c);
      rd_chk("desc_next", 8'h14, 32'h240);
      `CHK("owner_clear", 32'h0, mm.mem[134])
      `CHK("desc_bytes", 32'h8, mm.mem[129])
      `CHK("data0", 32'hc0de0000, mm.mem[256])
      wait_cyc <= 2'h2;
      frame(3, 1'b1);
      rd_chk("ptr_restore", 8'h0c, 32'h408);
      rd_chk("words_restore", 8'h10, 32'h3c);
      `CHK("no_desc", 32'hdead, mm.mem[144])
      frame(1, 1'b0);
      rd_chk("desc_exhaust", 8'h04, 32'h1);
      `CHK("owner_kept", 32'h1, mm.mem[150])
      rd_chk("ptr_third", 8'h0c, 32'h40c);
      frame(1, 1'b0);
      rd_chk("ptr_drop", 8'h0c, 32'h40c);
      mm.mem[149] = 32'h280;
      frame(1, 1'b0);
      `CHK("owner_release", 32'h0, mm.mem[150])
      rd_chk("desc_append", 8'h14, 32'h10280);
      apb(1'b1, 8'h14, 32'h2c0);
      apb(1'b1, 8'h10, 32'h2);
      frame(2, 1'b0);
      rd_chk("flags_all", 8'h04, 32'h7);
      rd_chk("ptr_new_area", 8'h0c, 32'h600);
      `CHK("trunc_no_desc", 32'hdead, mm.mem[176])
      apb(1'b1, 8'h10, 32'h4);
      frame(1, 1'b0);
      rd_chk("ring_hold", 8'h0c, 32'h604);
      apb(1'b1, 8'h04, 32'h2);
      wait_idle();
      rd_chk("ring_next", 8'h0c, 32'h800);
      rd_chk("ring_wrap", 8'h1c, 32'h100);
      finish_test();
   end
endmodule
